/* File: design/uabd_consts.vh */
// ==========================================================================
// constants for the auto-baud and break-detect receiver
// assumes one 100 MHz system clock and an 8-bit register port
// How it works
// - setting the auto-baud enable bit starts calibration and keeps ordinary reception idle.
// - during calibration the receive line times the divisor counter instead of the reverse.
// - the divisor counter starts counting at the first rising edge after the start bit.
// - at the fifth rising edge the count stays in the divisor pair, enable clears, flag sets.
// - software reads and discards the receive buffer after calibration to clear the flag.
// - during calibration both divisor bytes form one 16-bit counter whatever the width select.
// - the calibration counter runs at one eighth of the normal divisor base clock.
// - calibration clock is clk/512, clk/128 with one select bit set, clk/32 with both.
// - the calibration counter starts at one and software subtracts one afterwards.
// - with wake-on-break also enabled, calibration runs on the byte after the break.
// - a break shows as receive flag set, framing error set and received data 00h together.
// - wake-on-break samples two line transitions, flags, then receives the next byte and flags.
`ifndef UABD_CONSTS_VH
`define UABD_CONSTS_VH

// ==========================================================================
// register offsets
`define UABD_ADDR_CTRL      4'h0
`define UABD_ADDR_STATUS    4'h1
`define UABD_ADDR_RXBUF     4'h2
`define UABD_ADDR_DIV_LOW   4'h3
`define UABD_ADDR_DIV_HIGH  4'h4
`define UABD_ADDR_IRQ_STAT  4'h5
`define UABD_ADDR_IRQ_MASK  4'h6

// ==========================================================================
// control register fields
`define UABD_CTRL_AUTOBAUD  0
`define UABD_CTRL_WIDE      1
`define UABD_CTRL_HISPEED   2
`define UABD_CTRL_WAKE      3
`define UABD_CTRL_ASYNC     4
`define UABD_CTRL_RESET     5'h00

// ==========================================================================
// status and interrupt fields
`define UABD_ST_RXFLAG      0
`define UABD_ST_FRAMING_ERROR_FLAG        1
`define UABD_ST_IDLE        2
`define UABD_IRQ_BYTE       0
`define UABD_IRQ_BREAK      1
`define UABD_IRQ_CAL        2
`define UABD_IRQ_WAKE       3

// ==========================================================================
// reset values and counts
`define UABD_DIV_RESET      16'h0000
`define UABD_CAL_START      16'h0001
`define UABD_CAL_EDGES      3'h5
`define UABD_DATA_BITS      3'h7
`define UABD_MASK_64        9'h03F
`define UABD_MASK_16        9'h00F
`define UABD_MASK_4         9'h003

`endif

/* File: design/uabd_rate_gen.v */
// ==========================================================================
// divisor base clock and calibration clock pulses
// assumes the select bits come from registers on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "uabd_consts.vh"

module uabd_rate_gen (
    // clock and reset
    input  wire       CLK_SYS,
    input  wire       RESETN,
    // rate selection
    input  wire       WIDE_SEL,
    input  wire       HISPEED_SEL,
    // pulses
    output reg        BASE_TICK,
    output reg        CAL_TICK
);

    reg  [8:0] prescale_reg;
    wire [8:0] base_mask;
    wire [8:0] cal_mask;

    // ======================================================================
    // mask of the free counter giving the base clock period
    function [8:0] base_mask_of;
        input wide;
        input hs;
        begin
            case ({wide, hs})
                2'b00:   base_mask_of = `UABD_MASK_64;
                2'b11:   base_mask_of = `UABD_MASK_4;
                default: base_mask_of = `UABD_MASK_16;
            endcase
        end
    endfunction

    assign base_mask = base_mask_of(WIDE_SEL, HISPEED_SEL);
    // eight base periods: 512, 128 or 32 clocks
    assign cal_mask  = {base_mask[5:0], 3'b111};

    // ======================================================================
    // one free counter serves both pulses so they stay phase locked
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            prescale_reg <= 9'h000;
            BASE_TICK    <= 1'b0;
            CAL_TICK     <= 1'b0;
        end else begin
            prescale_reg <= prescale_reg + 9'h001;
            BASE_TICK    <= ((prescale_reg & base_mask) == base_mask);
            CAL_TICK     <= ((prescale_reg & cal_mask) == cal_mask);
        end
    end

endmodule
`default_nettype wire

/* File: design/uabd_receiver.v */
// ==========================================================================
// asynchronous receiver with auto-baud calibration and break detection
// assumes a plain register port and a receive line from outside the clock
`timescale 1ns/100ps
`default_nettype none
`include "uabd_consts.vh"

module uabd_receiver (
    // clock and reset
    input  wire        CLK_SYS,
    input  wire        RESETN,
    // register port
    input  wire [3:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [7:0]  RDATA,
    // serial line
    input  wire        SERIAL_RECEIVE_LINE,
    // interrupt
    output wire        IRQ
);

    // ======================================================================
    // states
    localparam ST_IDLE   = 4'h0;
    localparam ST_START  = 4'h1;
    localparam ST_DATA   = 4'h2;
    localparam ST_STOP   = 4'h3;
    localparam ST_AB_ST  = 4'h4; // waiting for the sync start bit
    localparam ST_AB_R1  = 4'h5; // waiting for the first rising edge
    localparam ST_AB_CNT = 4'h6; // counting while edges arrive
    localparam ST_WK_LO  = 4'h7; // wake: first transition
    localparam ST_WK_HI  = 4'h8; // wake: second transition

    // ======================================================================
    // declarations
    reg  [2:0]  rx_sync_reg;
    reg         rx_level_reg;
    reg  [3:0]  state_reg;
    reg  [15:0] bit_cnt_reg;
    reg  [2:0]  bit_idx_reg;
    reg  [2:0]  edge_cnt_reg;
    reg  [7:0]  shift_reg;
    reg  [7:0]  receive_buffer_reg;
    reg         framing_error_flag_reg;
    reg         receive_flag_reg;
    reg  [15:0] baud_divisor_reg;
    reg         autobaud_enable_reg;
    reg         wide_divisor_select_reg;
    reg         high_speed_select_reg;
    reg         wake_on_break_enable_reg;
    reg         async_enable_reg;
    reg  [3:0]  irq_stat_reg;
    reg  [3:0]  irq_mask_reg;
    wire        base_tick;
    wire        cal_tick;
    wire        rx_next;
    wire        rx_rise;
    wire        rx_fall;
    wire        receive_idle;
    wire        wr_ctrl;
    wire        rd_rxbuf;
    wire        rd_irq;
    reg         byte_done;
    reg         cal_done;
    reg         wake_done;
    reg  [7:0]  rd_mux;

    // ======================================================================
    // base and calibration clock pulses
    uabd_rate_gen u_rate (
        .CLK_SYS     (CLK_SYS),
        .RESETN      (RESETN),
        .WIDE_SEL    (wide_divisor_select_reg),
        .HISPEED_SEL (high_speed_select_reg),
        .BASE_TICK   (base_tick),
        .CAL_TICK    (cal_tick)
    );

    // ======================================================================
    // line synchroniser: level moves only when the last two stages agree
    assign rx_next = (rx_sync_reg[1] == rx_sync_reg[2]) ? rx_sync_reg[2] : rx_level_reg;
    assign rx_rise = rx_next & ~rx_level_reg;
    assign rx_fall = ~rx_next & rx_level_reg;

    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_sync_reg  <= 3'b111;
            rx_level_reg <= 1'b1;
        end else begin
            rx_sync_reg  <= {rx_sync_reg[1:0], SERIAL_RECEIVE_LINE};
            rx_level_reg <= rx_next;
        end
    end

    // ======================================================================
    // register port decodes
    assign wr_ctrl      = WR && (ADDR == `UABD_ADDR_CTRL);
    assign rd_rxbuf     = RD && (ADDR == `UABD_ADDR_RXBUF);
    assign rd_irq       = RD && (ADDR == `UABD_ADDR_IRQ_STAT);
    assign receive_idle = (state_reg == ST_IDLE);

    // ======================================================================
    // receive state machine; calibration and wake share it
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_reg              <= ST_IDLE;
            bit_cnt_reg            <= 16'h0000;
            bit_idx_reg            <= 3'h0;
            edge_cnt_reg           <= 3'h0;
            shift_reg              <= 8'h00;
            receive_buffer_reg     <= 8'h00;
            framing_error_flag_reg <= 1'b0;
            byte_done              <= 1'b0;
            cal_done               <= 1'b0;
            wake_done              <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            cal_done  <= 1'b0;
            wake_done <= 1'b0;
            if (!async_enable_reg) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        // wake first so calibration follows the break; done pulses bar re-entry
                        if (wake_on_break_enable_reg && !wake_done) begin
                            state_reg <= ST_WK_LO;
                        end else if (autobaud_enable_reg && !cal_done) begin
                            state_reg <= ST_AB_ST;
                        end else if (rx_fall) begin
                            bit_cnt_reg <= {1'b0, baud_divisor_reg[15:1]};
                            state_reg   <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (base_tick) begin
                            if (bit_cnt_reg != 16'h0000) begin
                                bit_cnt_reg <= bit_cnt_reg - 16'h0001;
                            end else if (!rx_level_reg) begin
                                bit_cnt_reg <= baud_divisor_reg;
                                bit_idx_reg <= 3'h0;
                                state_reg   <= ST_DATA;
                            end else begin
                                // glitch shorter than half a bit
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (base_tick) begin
                            if (bit_cnt_reg != 16'h0000) begin
                                bit_cnt_reg <= bit_cnt_reg - 16'h0001;
                            end else begin
                                bit_cnt_reg <= baud_divisor_reg;
                                shift_reg   <= {rx_level_reg, shift_reg[7:1]};
                                bit_idx_reg <= bit_idx_reg + 3'h1;
                                if (bit_idx_reg == `UABD_DATA_BITS) begin
                                    state_reg <= ST_STOP;
                                end
                            end
                        end
                    end
                    ST_STOP: begin
                        if (base_tick) begin
                            if (bit_cnt_reg != 16'h0000) begin
                                bit_cnt_reg <= bit_cnt_reg - 16'h0001;
                            end else begin
                                // a break lands here with data 00h and stop low
                                receive_buffer_reg     <= shift_reg;
                                framing_error_flag_reg <= ~rx_level_reg;
                                byte_done              <= 1'b1;
                                state_reg              <= ST_IDLE;
                            end
                        end
                    end
                    ST_AB_ST: begin
                        if (!autobaud_enable_reg) begin
                            state_reg <= ST_IDLE;
                        end else if (rx_fall) begin
                            state_reg <= ST_AB_R1;
                        end
                    end
                    ST_AB_R1: begin
                        if (rx_rise) begin
                            edge_cnt_reg <= 3'h1;
                            state_reg    <= ST_AB_CNT;
                        end
                    end
                    ST_AB_CNT: begin
                        // buffer untouched during calibration
                        if (rx_rise) begin
                            edge_cnt_reg <= edge_cnt_reg + 3'h1;
                            if (edge_cnt_reg == (`UABD_CAL_EDGES - 3'h1)) begin
                                cal_done  <= 1'b1;
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_WK_LO: begin
                        if (rx_fall) begin
                            state_reg <= ST_WK_HI;
                        end
                    end
                    ST_WK_HI: begin
                        if (rx_rise) begin
                            wake_done <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // divisor pair: software value, or the 16-bit calibration counter
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            baud_divisor_reg <= `UABD_DIV_RESET;
        end else if (state_reg == ST_AB_R1 && rx_rise) begin
            baud_divisor_reg <= `UABD_CAL_START;
        end else if (state_reg == ST_AB_CNT) begin
            // the line, not the divisor, sets the interval; full 16 bits
            if (cal_tick && !(rx_rise && edge_cnt_reg == (`UABD_CAL_EDGES - 3'h1))) begin
                baud_divisor_reg <= baud_divisor_reg + 16'h0001;
            end
        end else if (state_reg != ST_AB_R1 && !autobaud_enable_reg && WR) begin
            if (ADDR == `UABD_ADDR_DIV_LOW) begin
                baud_divisor_reg[7:0] <= WDATA;
            end else if (ADDR == `UABD_ADDR_DIV_HIGH) begin
                baud_divisor_reg[15:8] <= WDATA;
            end
        end
    end

    // ======================================================================
    // control register; hardware clears enables when its sequence ends
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            {async_enable_reg, wake_on_break_enable_reg, high_speed_select_reg,
             wide_divisor_select_reg, autobaud_enable_reg} <= `UABD_CTRL_RESET;
            irq_mask_reg <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                autobaud_enable_reg      <= WDATA[`UABD_CTRL_AUTOBAUD];
                wide_divisor_select_reg  <= WDATA[`UABD_CTRL_WIDE];
                high_speed_select_reg    <= WDATA[`UABD_CTRL_HISPEED];
                wake_on_break_enable_reg <= WDATA[`UABD_CTRL_WAKE];
                async_enable_reg         <= WDATA[`UABD_CTRL_ASYNC];
            end
            if (cal_done) begin
                autobaud_enable_reg <= 1'b0;
            end
            if (wake_done) begin
                wake_on_break_enable_reg <= 1'b0;
            end
            if (WR && ADDR == `UABD_ADDR_IRQ_MASK) begin
                irq_mask_reg <= WDATA[3:0];
            end
        end
    end

    // ======================================================================
    // receive flag: read of the buffer clears, a new event wins
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            receive_flag_reg <= 1'b0;
        end else if (byte_done || cal_done || wake_done) begin
            receive_flag_reg <= 1'b1;
        end else if (rd_rxbuf) begin
            receive_flag_reg <= 1'b0;
        end
    end

    // ======================================================================
    // sticky interrupt status, cleared by reading it; set beats clear
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            irq_stat_reg <= 4'h0;
        end else begin
            irq_stat_reg <= (rd_irq ? 4'h0 : irq_stat_reg)
                          | {wake_done, cal_done,
                             byte_done & ~rx_level_reg & (shift_reg == 8'h00), byte_done};
        end
    end

    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    // ======================================================================
    // read data, one cycle after the strobe; unmapped reads give zero
    always @* begin
        case (ADDR)
            `UABD_ADDR_CTRL:     rd_mux = {3'b000, async_enable_reg, wake_on_break_enable_reg,
                                           high_speed_select_reg, wide_divisor_select_reg,
                                           autobaud_enable_reg};
            `UABD_ADDR_STATUS:   rd_mux = {5'b00000, receive_idle, framing_error_flag_reg,
                                           receive_flag_reg};
            `UABD_ADDR_RXBUF:    rd_mux = receive_buffer_reg;
            `UABD_ADDR_DIV_LOW:  rd_mux = baud_divisor_reg[7:0];
            `UABD_ADDR_DIV_HIGH: rd_mux = baud_divisor_reg[15:8];
            `UABD_ADDR_IRQ_STAT: rd_mux = {4'h0, irq_stat_reg};
            `UABD_ADDR_IRQ_MASK: rd_mux = {4'h0, irq_mask_reg};
            default:             rd_mux = 8'h00;
        endcase
    end

    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? rd_mux : 8'h00;
        end
    end

endmodule
`default_nettype wire

/* File: dv/uabd_receiver_asserts.sv */
// checker for the receiver register port and interrupt output
// assumes it is bound to uabd_receiver and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "uabd_consts.vh"

module uabd_receiver_chk (
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RESETN,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    // line and interrupt
    input wire logic       SERIAL_RECEIVE_LINE,
    input wire logic       IRQ
);
    // ==========
    // shadows of software-owned bits
    logic [7:0] mask_reg;
    logic [7:0] ctrl_reg;

    // shadows follow software writes
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            mask_reg <= 8'h00;
            ctrl_reg <= 8'h00;
        end else if (WR && ADDR == `UABD_ADDR_IRQ_MASK) begin
            mask_reg <= WDATA;
        end else if (WR && ADDR == `UABD_ADDR_CTRL) begin
            ctrl_reg <= WDATA;
        end
    end

    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    // ==========
    // read steps
    sequence buf_read_s;
        RD && ADDR == `UABD_ADDR_RXBUF;
    endsequence
    sequence stat_read_s;
        RD && ADDR == `UABD_ADDR_STATUS;
    endsequence
    sequence irq_read_s;
        RD && ADDR == `UABD_ADDR_IRQ_STAT;
    endsequence

    rdata_quiet_a: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (RD && ADDR > 4'h6 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    irq_masked_a: assert property (mask_reg[3:0] == 4'h0 |-> !IRQ)
        else $error("interrupt high with all sources masked");
    irq_fall_cause_a: assert property ($fell(IRQ) |-> ($past(RD) &&
        $past(ADDR) == `UABD_ADDR_IRQ_STAT) || ($past(WR) && $past(ADDR) == 4'h6))
        else $error("interrupt dropped without read or mask write");
    ctrl_readback_a: assert property (RD && ADDR == `UABD_ADDR_CTRL |=>
        RDATA[2:1] == ctrl_reg[2:1] && RDATA[4] == ctrl_reg[4])
        else $error("control bits read back wrong");
    flag_clear_a: assert property (buf_read_s ##1 stat_read_s |=> !RDATA[0])
        else $error("receive flag survived buffer read");
    stat_clear_a: assert property (irq_read_s ##1 irq_read_s |=> RDATA[3:0] == 4'h0)
        else $error("interrupt status not cleared by read");
    break_pair_a: assert property (irq_read_s |=> !RDATA[1] || RDATA[0])
        else $error("break event without received byte");
endmodule

bind uabd_receiver uabd_receiver_chk uabd_receiver_chk_i (
    .CLK_SYS             (CLK_SYS),
    .RESETN              (RESETN),
    .ADDR                (ADDR),
    .WDATA               (WDATA),
    .WR                  (WR),
    .RD                  (RD),
    .RDATA               (RDATA),
    .SERIAL_RECEIVE_LINE (SERIAL_RECEIVE_LINE),
    .IRQ                 (IRQ)
);
`default_nettype wire

/* File: dv/uabd_line_tx.sv */
// remote serial transmitter on the far side of the receive line
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/100ps
`default_nettype none

module uabd_line_tx (
    // clock
    input  wire logic CLK_SYS,
    // serial line
    output var  logic LINE
);
    // ==========
    // idle line rests high like a pulled-up wire
    initial LINE = 1'b1;

    // start, eight bits lsb first, stop; a low stop with zero data makes a break
    task automatic send(input logic [7:0] d, input int bt, input logic stop);
        logic [9:0] frame;
        frame = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge CLK_SYS);
            LINE <= frame[i];
            repeat (bt - 1) @(posedge CLK_SYS);
        end
        if (!stop) begin
            @(posedge CLK_SYS);
            LINE <= 1'b1;
        end
    endtask

    // one low pulse: a falling then a rising transition
    task automatic low_pulse(input int n);
        @(posedge CLK_SYS);
        LINE <= 1'b0;
        repeat (n) @(posedge CLK_SYS);
        LINE <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: dv/uabd_receiver_tb.sv */
// self-checking bench for the auto-baud and break receiver
// assumes the design files and the line model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "uabd_consts.vh"

module uabd_receiver_tb;
    // ==========
    // signals and bookkeeping
    logic       CLK_SYS = 1'b0;
    logic       RESETN = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    logic       WR = 1'b0;
    logic       RD = 1'b0;
    wire  [7:0] RDATA;
    wire        LINE;
    wire        IRQ;
    logic       rd_seen = 1'b0;
    logic [15:0] lf = 16'h073A;
    logic [23:0] note;
    logic [23:0] exp_q[$];
    int         err_count = 0;
    int         comparisons = 0;
    localparam int CAL_BIT = 32'h410;

    always #5 CLK_SYS = ~CLK_SYS;

    uabd_receiver uabd_receiver_i (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SERIAL_RECEIVE_LINE(LINE),
        .IRQ(IRQ));
    uabd_line_tx uabd_line_tx_i (.CLK_SYS(CLK_SYS), .LINE(LINE));

    // ==========
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // tolerance covers the free-running calibration tick phase
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input logic [7:0] msk, input logic [7:0] tol = 8'h00);
        logic bad = 1'b1;
        comparisons++;
        for (int k = 0; k <= 2 * tol; k++)
            if ((seen & msk) === ((exp + k[7:0] - tol) & msk)) bad = 1'b0;
        if (bad) begin
            err_count++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    // strobes stand until the next call
    task automatic bus(input logic w, input logic r, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge CLK_SYS);
        WR <= w;
        RD <= r;
        ADDR <= a;
        WDATA <= d;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m,
                      input logic [7:0] t = 8'h00);
        exp_q.push_back({e, m, t});
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle();
        bus(1'b0, 1'b0, 4'h0, 8'h00);
    endtask

    task automatic wait_irq();
        int k = 0;
        while (IRQ !== 1'b1 && k < 30000) begin
            @(posedge CLK_SYS);
            k++;
        end
        if (k >= 30000) begin
            err_count++;
            $display("[ERR] %0t interrupt never came", $time);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // read data is valid only in the cycle after the strobe
    always @(posedge CLK_SYS) begin
        if (rd_seen && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check(RDATA, note[23:16], note[15:8], note[7:0]);
        end
        rd_seen <= RD;
    end

    // ==========
    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] c;
        int tick;
        logic [15:0] n;
        repeat (12) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        // divisor 7 at base 4 gives 32 clocks a bit
        wr(`UABD_ADDR_DIV_LOW, 8'h07);
        wr(`UABD_ADDR_DIV_HIGH, 8'h00);
        wr(`UABD_ADDR_IRQ_MASK, 8'h0F);
        wr(`UABD_ADDR_CTRL, 8'h16);
        rd(`UABD_ADDR_CTRL, 8'h16, 8'h16);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00, 8'hFF);
        idle();
        // random bytes, read-clear of flag and interrupt status
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            d = lf[7:0];
            uabd_line_tx_i.send(d, 32, 1'b1);
            wait_irq();
            rd(`UABD_ADDR_RXBUF, d, 8'hFF);
            rd(`UABD_ADDR_STATUS, 8'h00, 8'h01);
            rd(`UABD_ADDR_IRQ_STAT, 8'h01, 8'h0F);
            rd(`UABD_ADDR_IRQ_STAT, 8'h00, 8'h0F);
            idle();
        end
        // masked event stays silent until unmasked
        wr(`UABD_ADDR_IRQ_MASK, 8'h00);
        idle();
        uabd_line_tx_i.send(8'h3C, 32, 1'b1);
        repeat (40) @(posedge CLK_SYS);
        check(8'(IRQ), 8'h00, 8'h01);
        wr(`UABD_ADDR_IRQ_MASK, 8'h01);
        idle();
        @(posedge CLK_SYS);
        check(8'(IRQ), 8'h01, 8'h01);
        rd(`UABD_ADDR_IRQ_STAT, 8'h01, 8'h0F);
        rd(`UABD_ADDR_RXBUF, 8'h3C, 8'hFF);
        idle();
        @(posedge CLK_SYS);
        check(8'(IRQ), 8'h00, 8'h01);
        wr(`UABD_ADDR_IRQ_MASK, 8'h0F);
        idle();
        // break: zero data with a low stop bit
        uabd_line_tx_i.send(8'h00, 32, 1'b0);
        wait_irq();
        rd(`UABD_ADDR_STATUS, 8'h07, 8'h07);
        rd(`UABD_ADDR_IRQ_STAT, 8'h03, 8'h0F);
        rd(`UABD_ADDR_RXBUF, 8'h00, 8'hFF);
        idle();
        // calibration in every rate selection
        for (int m = 0; m < 4; m++) begin
            c = {4'h1, 1'b0, m[0], m[1], 1'b1};
            tick = (m == 0) ? 512 : (m == 3) ? 32 : 128;
            n = 16'h0001 + 16'(8 * CAL_BIT / tick);
            wr(`UABD_ADDR_CTRL, c);
            idle();
            uabd_line_tx_i.send(8'h55, CAL_BIT, 1'b1);
            wait_irq();
            rd(`UABD_ADDR_CTRL, c & 8'hFE, 8'h17);
            rd(`UABD_ADDR_STATUS, 8'h05, 8'h05);
            rd(`UABD_ADDR_DIV_LOW, n[7:0], 8'hFF, 8'h01);
            rd(`UABD_ADDR_DIV_HIGH, n[15:8], 8'hFF);
            rd(`UABD_ADDR_IRQ_STAT, 8'h04, 8'h04);
            rd(`UABD_ADDR_RXBUF, 8'h00, 8'hFF);
            idle();
        end
        // wake transitions first, then calibration on the next byte
        wr(`UABD_ADDR_CTRL, 8'h1F);
        idle();
        uabd_line_tx_i.low_pulse(200);
        wait_irq();
        rd(`UABD_ADDR_IRQ_STAT, 8'h08, 8'h08);
        rd(`UABD_ADDR_CTRL, 8'h17, 8'h1F);
        idle();
        uabd_line_tx_i.send(8'h55, CAL_BIT, 1'b1);
        wait_irq();
        rd(`UABD_ADDR_DIV_LOW, 8'h05, 8'hFF, 8'h01);
        rd(`UABD_ADDR_IRQ_STAT, 8'h04, 8'h0C);
        rd(`UABD_ADDR_CTRL, 8'h16, 8'h1F);
        idle();
        repeat (4) @(posedge CLK_SYS);
        give_verdict();
    end

    // the full run needs about 55k cycles
    initial begin
        repeat (90000) @(posedge CLK_SYS);
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
